// file: include/fcts_pkg.sv
// package: command codes, cycle budgets and carrier types of the sequencer
package fcts_pkg;
    // command codes
    localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
    localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
    localparam logic [7:0] CMD_VERIFY_PSECT = 8'h03;
    localparam logic [7:0] CMD_READ_ONCE = 8'h04;
    localparam logic [7:0] CMD_PROG_PHRASE = 8'h06;
    localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
    localparam logic [7:0] CMD_ERASE_PBLOCK = 8'h09;
    localparam logic [7:0] CMD_ERASE_PSECT = 8'h0A;
    localparam logic [7:0] CMD_UNSECURE = 8'h0B;
    localparam logic [7:0] CMD_VERIFY_KEY = 8'h0C;
    localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
    localparam logic [7:0] CMD_VERIFY_DSECT = 8'h10;
    localparam logic [7:0] CMD_PROG_DWORDS = 8'h11;
    localparam logic [7:0] CMD_ERASE_DSECT = 8'h12;
    // bus-cycle budgets
    localparam logic [31:0] BUS_VERIFY_ALL = 32'd35500;
    localparam logic [31:0] BUS_VERIFY_PBLK = 32'd33500;
    localparam logic [31:0] BUS_VERIFY_DBLK = 32'd2800;
    localparam logic [31:0] BUS_SECT_SETUP = 32'd450;
    localparam logic [31:0] BUS_READ_ONCE = 32'd400;
    localparam logic [31:0] BUS_PROG_TYP = 32'd2000;
    localparam logic [31:0] BUS_PROG_MAX = 32'd2500;
    localparam logic [31:0] BUS_PROG_ONCE = 32'd2150;
    localparam logic [31:0] BUS_ERASE_ALL = 32'd70000;
    localparam logic [31:0] BUS_ERASE_PBLK = 32'd67000;
    localparam logic [31:0] BUS_PSECT_TYP = 32'd700;
    localparam logic [31:0] BUS_PSECT_MAX = 32'd1400;
    localparam logic [31:0] BUS_KEY = 32'd400;
    localparam logic [31:0] BUS_MARGIN = 32'd350;
    localparam logic [31:0] BUS_DPGM_BASE = 32'd500;
    localparam logic [31:0] BUS_DPGM_TYP = 32'd525;
    localparam logic [31:0] BUS_DPGM_MAX = 32'd750;
    localparam logic [31:0] BUS_DPGM_BC = 32'd100;
    localparam logic [31:0] BUS_DSECT_TYP = 32'd700;
    localparam logic [31:0] BUS_DSECT_MAX = 32'd3400;
    // operation-clock budgets
    localparam logic [31:0] OP_PROG = 32'd164;
    localparam logic [31:0] OP_MASS = 32'd100100;
    localparam logic [31:0] OP_PSECT = 32'd20020;
    localparam logic [31:0] OP_DPGM_BASE = 32'd14;
    localparam logic [31:0] OP_DPGM_WORD = 32'd54;
    localparam logic [31:0] OP_DPGM_BC = 32'd14;
    localparam logic [31:0] OP_DSECT_TYP = 32'd5025;
    localparam logic [31:0] OP_DSECT_MAX = 32'd20100;
    // operation clock limits in kHz and the bus clock rate
    localparam int OP_MIN_KHZ = 800;
    localparam int OP_MAX_KHZ = 1050;
    localparam int BUS_KHZ = 100000;
    // request carrier
    typedef struct packed {
        logic [7:0] code;
        logic dataArray;
        logic rowBoundaryCrossed;
        logic [2:0] wordCount;
        logic [15:0] phrasesToVerify;
        logic [15:0] firstNonBlank;
        logic nonBlankFound;
        logic worstCase;
    } fcts_req_t;
    // status carrier
    typedef struct packed {
        logic busy;
        logic done;
        logic rejected;
        logic nonBlank;
        logic arrayWrite;
    } fcts_stat_t;
endpackage

// file: core/fcts_sequencer.sv
// file: command timing sequencer for program and data nvm arrays
`timescale 1ns/1ps
module fcts_sequencer
    import fcts_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // divider setting: operation clock = bus clock / (div + 1)
    input wire logic [DIV_W-1:0] nvm_clock_divider_reg,
    // command launch
    input wire logic launch,
    input wire fcts_req_t req,
    // status with array write strobe, and elapsed bus cycles
    output fcts_stat_t status,
    output logic [31:0] elapsedBus
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BUS = 4'b0010,
        ST_OP = 4'b0100,
        ST_DONE = 4'b1000
    } fcts_state_t;

    // bus cycles of a command; zero means unknown
    function automatic logic [31:0] busBudget(input fcts_req_t r);
        logic [31:0] n;
        logic [31:0] scan;
        n = 32'd0;
        scan = r.nonBlankFound ? {16'h0000, r.firstNonBlank} : 32'd0;
        case (r.code)
            CMD_VERIFY_ALL: n = r.nonBlankFound ?
                BUS_SECT_SETUP + scan : BUS_VERIFY_ALL;
            CMD_VERIFY_BLOCK: n = r.nonBlankFound ? BUS_SECT_SETUP + scan :
                (r.dataArray ? BUS_VERIFY_DBLK : BUS_VERIFY_PBLK);
            CMD_VERIFY_PSECT, CMD_VERIFY_DSECT: n = BUS_SECT_SETUP +
                (r.nonBlankFound ? scan : {16'h0000, r.phrasesToVerify});
            CMD_READ_ONCE: n = BUS_READ_ONCE;
            CMD_PROG_PHRASE: n = r.worstCase ? BUS_PROG_MAX : BUS_PROG_TYP;
            CMD_PROG_ONCE: n = BUS_PROG_ONCE;
            CMD_ERASE_ALL, CMD_UNSECURE: n = BUS_ERASE_ALL;
            CMD_ERASE_PBLOCK: n = BUS_ERASE_PBLK;
            CMD_ERASE_PSECT: n = r.worstCase ? BUS_PSECT_MAX : BUS_PSECT_TYP;
            CMD_VERIFY_KEY: n = BUS_KEY;
            CMD_USER_MARGIN, CMD_FIELD_MARGIN: n = BUS_MARGIN;
            CMD_PROG_DWORDS: n = BUS_DPGM_BASE
                + (r.worstCase ? BUS_DPGM_MAX : BUS_DPGM_TYP)
                  * {29'd0, r.wordCount}
                + (r.rowBoundaryCrossed ? BUS_DPGM_BC : 32'd0);
            CMD_ERASE_DSECT: n = r.worstCase ?
                BUS_DSECT_MAX : BUS_DSECT_TYP;
            default: n = 32'd0;
        endcase
        return n;
    endfunction

    // operation-clock cycles of a program or erase step
    function automatic logic [31:0] opBudget(input fcts_req_t r);
        logic [31:0] n;
        n = 32'd0;
        case (r.code)
            CMD_PROG_PHRASE, CMD_PROG_ONCE: n = OP_PROG;
            CMD_ERASE_ALL, CMD_ERASE_PBLOCK, CMD_UNSECURE: n = OP_MASS;
            CMD_ERASE_PSECT: n = OP_PSECT;
            CMD_PROG_DWORDS: n = OP_DPGM_BASE
                + OP_DPGM_WORD * {29'd0, r.wordCount}
                + (r.rowBoundaryCrossed ? OP_DPGM_BC : 32'd0);
            CMD_ERASE_DSECT: n = r.worstCase ?
                OP_DSECT_MAX : OP_DSECT_TYP;
            default: n = 32'd0;
        endcase
        return n;
    endfunction

    // a request is legal when its code is known and its word count valid
    function automatic logic legal(input fcts_req_t r);
        logic ok;
        ok = busBudget(r) != 32'd0;
        if (r.code == CMD_PROG_DWORDS) begin
            ok = ok && r.wordCount >= 3'd1 && r.wordCount <= 3'd4
                && (!r.rowBoundaryCrossed || r.wordCount == 3'd4);
        end
        return ok;
    endfunction

    fcts_state_t state_ff;
    fcts_state_t nxt_state;
    logic [31:0] busLeft_ff;
    logic [31:0] opLeft_ff;
    logic [DIV_W-1:0] divCnt_ff;
    logic [DIV_W-1:0] divLatch_ff;
    logic [31:0] elapsed_ff;
    fcts_stat_t stat_ff;
    logic writes_ff;
    logic opTick;

    // operation-clock tick; frequency never checked, never blocks
    assign opTick = (divCnt_ff == divLatch_ff);

    // state sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (launch && legal(req)) begin
                nxt_state = ST_BUS;
            end
            ST_BUS: if (busLeft_ff <= 32'd1) begin
                nxt_state = (opLeft_ff != 32'd0) ? ST_OP : ST_DONE;
            end
            ST_OP: if (opTick && opLeft_ff == 32'd1) begin
                nxt_state = ST_DONE;
            end
            ST_DONE: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // cycle budgets loaded at launch and counted down
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busLeft_ff <= 32'd0;
            opLeft_ff <= 32'd0;
            writes_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && launch && legal(req)) begin
            busLeft_ff <= busBudget(req);
            opLeft_ff <= opBudget(req);
            writes_ff <= opBudget(req) != 32'd0;
        end else if (state_ff == ST_BUS && busLeft_ff != 32'd0) begin
            busLeft_ff <= busLeft_ff - 32'd1;
        end else if (state_ff == ST_OP && opTick) begin
            opLeft_ff <= opLeft_ff - 32'd1;
        end
    end

    // divider for the operation clock, latched at launch
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            divCnt_ff <= '0;
            divLatch_ff <= '0;
        end else if (state_ff == ST_IDLE) begin
            divCnt_ff <= '0;
            divLatch_ff <= nvm_clock_divider_reg;
        end else if (state_ff == ST_OP) begin
            divCnt_ff <= opTick ? '0 : divCnt_ff + 1'b1;
        end
    end

    // elapsed bus cycles of the running command
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            elapsed_ff <= 32'd0;
        end else if (state_ff == ST_IDLE && launch && legal(req)) begin
            elapsed_ff <= 32'd0;
        end else if (state_ff == ST_BUS || state_ff == ST_OP) begin
            elapsed_ff <= elapsed_ff + 32'd1;
        end
    end

    // status flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stat_ff <= '0;
        end else begin
            stat_ff.busy <= nxt_state == ST_BUS || nxt_state == ST_OP;
            stat_ff.done <= nxt_state == ST_DONE;
            stat_ff.rejected <= state_ff == ST_IDLE && launch
                && !legal(req);
            if (state_ff == ST_IDLE && launch && legal(req)) begin
                stat_ff.nonBlank <= req.nonBlankFound;
            end
            stat_ff.arrayWrite <= nxt_state == ST_DONE && writes_ff;
        end
    end

    assign status = stat_ff;
    assign elapsedBus = elapsed_ff;

    // done follows busy by exactly one cycle
    a_done_after_busy: assert property (@(posedge ref_clk) disable iff (srst)
        status.done |-> $past(status.busy))
        else $error("done without prior busy");
    // a rejected code never starts busy
    a_reject_no_busy: assert property (@(posedge ref_clk) disable iff (srst)
        status.rejected |-> !status.busy && !status.done
        ##1 !status.done && !status.arrayWrite)
        else $error("rejected command went busy");
    // read once finishes within its budget
    a_read_once_time: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ST_IDLE && launch && req.code == CMD_READ_ONCE)
        |-> ##[1:402] status.done)
        else $error("read once overran");
    // margin setting finishes within its budget
    a_margin_time: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ST_IDLE && launch && (req.code == CMD_USER_MARGIN
        || req.code == CMD_FIELD_MARGIN)) |-> ##[1:352] status.done)
        else $error("margin set overran");
    // key verify finishes within its budget
    a_key_time: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ST_IDLE && launch && req.code == CMD_VERIFY_KEY)
        |-> ##[1:402] status.done)
        else $error("key verify overran");
    // full and block verify commands never strobe array write
    a_verify_no_write: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ST_IDLE && launch && (req.code == CMD_VERIFY_ALL
        || req.code == CMD_VERIFY_BLOCK)) |=> !writes_ff)
        else $error("verify wrote array");
    // bus budget counted before any operation tick
    a_op_after_bus: assert property (@(posedge ref_clk) disable iff (srst)
        state_ff == ST_OP |-> busLeft_ff <= 32'd1)
        else $error("op phase started early");
    // busy stays up while counting
    a_busy_held: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ST_BUS && busLeft_ff > 32'd2) |=> status.busy)
        else $error("busy dropped early");
endmodule // fcts_sequencer

// file: dv/test_flash_command_timing_sequencer.sv
// testbench: command durations, rejections and busy handling of the sequencer
`timescale 1ns/1ps
module test_flash_command_timing_sequencer;
    import fcts_pkg::*;
    logic ref_clk;
    logic srst;
    logic [7:0] divReg;
    logic launch;
    fcts_req_t req;
    fcts_stat_t status;
    logic [31:0] elapsedBus;
    int n_fail;
    int check_count;

    fcts_sequencer #(.DIV_W(8)) i_fcts_sequencer (.ref_clk(ref_clk),
        .srst(srst), .nvm_clock_divider_reg(divReg), .launch(launch),
        .req(req), .status(status), .elapsedBus(elapsedBus));

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // compare a count against an inclusive window
    task automatic check_val(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi, input string msg);
        check_count++;
        if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %0d want %0d..%0d",
                     $time, msg, got, lo, hi);
        end
    endtask

    // compare one status bit
    task automatic check_bit(input logic got, input logic exp,
                             input string msg);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %b", $time, msg, got);
        end
    endtask

    // inputs move 1 ns after the rising edge
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    function automatic fcts_req_t mk(input logic [7:0] c, input logic d,
        input logic bc, input logic [2:0] w, input logic [15:0] p,
        input logic [15:0] f, input logic nb, input logic wc);
        fcts_req_t r;
        r = '0;
        r.code = c;
        r.dataArray = d;
        r.rowBoundaryCrossed = bc;
        r.wordCount = w;
        r.phrasesToVerify = p;
        r.firstNonBlank = f;
        r.nonBlankFound = nb;
        r.worstCase = wc;
        return r;
    endfunction

    // launch one legal command, count cycles to done, judge the status
    task automatic run_cmd(input fcts_req_t r, input logic [7:0] div,
                           input int exp, input logic expWr, input logic poke);
        int n;
        logic sawRej;
        logic busyLow;
        divReg = div;
        req = r;
        launch = 1'b1;
        tick();
        launch = 1'b0;
        n = 0;
        sawRej = 1'b0;
        busyLow = 1'b0;
        while (status.done !== 1'b1 && n < exp + 100) begin
            tick();
            n++;
            if (poke && n == 10) begin
                launch = 1'b1;
                req.code = 8'hFF;
            end
            if (poke && n == 11) begin
                launch = 1'b0;
                req = r;
            end
            if (status.rejected === 1'b1) sawRej = 1'b1;
            if (status.done !== 1'b1 && status.busy !== 1'b1) busyLow = 1'b1;
        end
        if (status.done !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED %0t no completion", $time);
            results();
        end
        check_val(32'(n), 32'(exp), 32'(exp + 3), "duration");
        check_bit(status.arrayWrite, expWr, "array write strobe");
        check_bit(status.busy, 1'b0, "busy with done");
        check_bit(busyLow, 1'b0, "busy gap");
        check_bit(sawRej, 1'b0, "launch while busy");
        check_val(elapsedBus, 32'(exp), 32'(exp + 3), "elapsed count");
        // let the done cycle pass so the next launch meets an idle state
        tick();
    endtask

    // launch an illegal request and expect only a rejection
    task automatic reject_cmd(input fcts_req_t r);
        logic seen;
        logic act;
        req = r;
        launch = 1'b1;
        tick();
        launch = 1'b0;
        seen = 1'b0;
        act = 1'b0;
        repeat (3) begin
            if (status.rejected === 1'b1) seen = 1'b1;
            if (status.busy !== 1'b0 || status.done !== 1'b0) act = 1'b1;
            if (status.arrayWrite !== 1'b0) act = 1'b1;
            tick();
        end
        check_bit(seen, 1'b1, "rejection pulse");
        check_bit(act, 1'b0, "activity on illegal code");
    endtask

    // fixed-time commands, back to back
    task automatic t_short();
        logic [7:0] codes [4] = '{8'h04, 8'h0C, 8'h0D, 8'h0E};
        int budg [4] = '{400, 400, 350, 350};
        for (int i = 0; i < 4; i++) begin
            run_cmd(mk(codes[i], 0, 0, 0, 0, 0, 0, 0), 0, budg[i], 0, 0);
        end
    endtask

    // blank checks, full and early end
    task automatic t_blank();
        run_cmd(mk(8'h01, 0, 0, 0, 0, 0, 0, 0), 0, 35500, 0, 0);
        run_cmd(mk(8'h02, 1, 0, 0, 0, 0, 0, 0), 0, 2800, 0, 0);
        check_bit(status.nonBlank, 1'b0, "blank result");
        run_cmd(mk(8'h03, 0, 0, 0, 100, 0, 0, 0), 0, 550, 0, 0);
        run_cmd(mk(8'h10, 1, 0, 0, 7, 0, 0, 0), 0, 457, 0, 0);
        run_cmd(mk(8'h02, 0, 0, 0, 0, 20, 1, 0), 0, 470, 0, 0);
        check_bit(status.nonBlank, 1'b1, "non-blank result");
    endtask

    // program commands, typical, worst case and a slower op clock
    task automatic t_program();
        run_cmd(mk(8'h06, 0, 0, 0, 0, 0, 0, 0), 0, 2164, 1, 0);
        run_cmd(mk(8'h06, 0, 0, 0, 0, 0, 0, 1), 0, 2664, 1, 0);
        run_cmd(mk(8'h06, 0, 0, 0, 0, 0, 0, 0), 1, 2328, 1, 0);
        run_cmd(mk(8'h07, 0, 0, 0, 0, 0, 0, 0), 0, 2314, 1, 0);
    endtask

    // data words: 1 to 4, crossing, and the maximum figure
    task automatic t_dwords();
        for (int w = 1; w <= 4; w++) begin
            run_cmd(mk(8'h11, 1, 0, 3'(w), 0, 0, 0, 0), 0,
                    14 + 54 * w + 500 + 525 * w, 1, 0);
        end
        run_cmd(mk(8'h11, 1, 1, 4, 0, 0, 0, 0), 0, 2944, 1, 0);
        run_cmd(mk(8'h11, 1, 0, 1, 0, 0, 0, 1), 0, 1318, 1, 0);
        // op clock at 100 MHz / 96, inside the allowed band
        run_cmd(mk(8'h11, 1, 0, 1, 0, 0, 0, 0), 95, 7553, 1, 0);
    endtask

    // sector erases
    task automatic t_erase();
        run_cmd(mk(8'h0A, 0, 0, 0, 0, 0, 0, 0), 0, 20720, 1, 0);
        run_cmd(mk(8'h12, 1, 0, 0, 0, 0, 0, 0), 0, 5725, 1, 0);
    endtask

    // illegal codes and word counts, then a launch during a command
    task automatic t_reject();
        reject_cmd(mk(8'h00, 0, 0, 0, 0, 0, 0, 0));
        reject_cmd(mk(8'h05, 0, 0, 0, 0, 0, 0, 0));
        reject_cmd(mk(8'hFF, 0, 0, 0, 0, 0, 0, 0));
        reject_cmd(mk(8'h11, 1, 0, 0, 0, 0, 0, 0));
        reject_cmd(mk(8'h11, 1, 0, 5, 0, 0, 0, 0));
        reject_cmd(mk(8'h11, 1, 1, 3, 0, 0, 0, 0));
        run_cmd(mk(8'h04, 0, 0, 0, 0, 0, 0, 0), 0, 400, 0, 1);
    endtask

    // reset, then every scenario
    initial begin
        n_fail = 0;
        check_count = 0;
        srst = 1'b1;
        launch = 1'b0;
        divReg = 8'h00;
        req = '0;
        repeat (4) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        check_bit(status === '0, 1'b1, "status after reset");
        check_val(elapsedBus, 0, 0, "elapsed after reset");
        t_short();
        t_blank();
        t_program();
        t_dwords();
        t_erase();
        t_reject();
        results();
    end
endmodule // test_flash_command_timing_sequencer
